// ===== hdl/hbc_boost_ctrl.v
// Boost configuration, strap sampling and mode control of the conditioner
//
// Notes on behaviour
// (RULE1) DC strap low/mid/high selects 40, 60, 80 mV Dc_gain_strap_pin.
// (RULE2) AC strap resistor level selects one of four AC boost levels.
// (RULE3) Low-speed link: compensation off, connection detect high.
// (RULE4) Full-speed link: compensation off, connection detect high.
// (RULE5) High-speed link: compensation on with configured levels, detect high.
// (RULE6) Chip disable low: shutdown, no compensation, no detect status.
// (RULE7) Disable pulse counts only if low at least 20 us.
// (RULE8) I2C enabled only if SCL and SDA high shortly after release.
// (RULE9) I2C target at 7-bit address 0x2C, 100 kHz.
// (RULE10) Host sets then clears hold bit after changing boost levels.
// (RULE11) AC level field bits 6:4 at 0x01 coded 000/001/011/111.
// (RULE12) AC level field loads from sampled AC strap at reset.
// (RULE13) Hold bit 0 at 0x03 resets to 1; 1 stops state machine.
// (RULE14) Hold stays set in I2C mode until written; else self-clears.
// (RULE15) Host preserves reserved fields by read-modify-write.
// (RULE16) DC level field bits 2:0 at 0x0E coded 011/101/111, from strap.
// (RULE17) Straps latched only at reset; change needs disable toggle.
// (RULE18) Byte registers: offset byte then data; reads use last offset.
// (RULE19) Disable restores register reset values and re-samples straps.
`include "hbc_map.vh"
module hbc_boost_ctrl #(
  parameter DISABLE_MIN_CYC = `HBC_DISABLE_MIN_CYC
) (
  input wire clock_i,
  input wire resetn_i,
  input wire chip_disable_n_i,
  input wire [1:0] ac_boost_strap_pin_i,
  input wire [1:0] dc_gain_strap_pin_i,
  input wire [1:0] link_speed_i,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  output reg comp_enable_o,
  output reg [2:0] ac_gain_level_o,
  output reg [2:0] dc_gain_level_o,
  output reg connection_detect_out_o,
  output reg i2c_mode_o
);
  localparam ST_OFF = 2'h0;
  localparam ST_SAMPLE = 2'h1;
  localparam ST_RUN = 2'h2;
  reg [1:0] dis_s1_ff, dis_s2_ff;
  reg [1:0] scl_s_ff, sda_s_ff;
  reg [1:0] spd_s1_ff, spd_s2_ff;
  reg [3:0] ac_s1_ff, ac_s2_ff;
  reg [3:0] dc_s1_ff, dc_s2_ff;
  reg [31:0] low_cnt_ff;
  reg active_ff;
  reg [1:0] state_ff;
  reg [4:0] wait_ff;
  reg [2:0] ac_gain_level_ff;
  reg [2:0] dc_gain_level_ff;
  reg cfg_hold_ff;
  wire wr_stb;
  wire [7:0] wr_ofs, wr_data, rd_ofs;
  reg [7:0] rd_data;
  wire disable_pin = dis_s2_ff[1];
  wire scl_sync = scl_s_ff[1];
  wire sda_sync = sda_s_ff[1];

  function [2:0] ac_code;
    input [1:0] lvl;
    begin
      case (lvl) // RULE2 RULE11
        2'h0: ac_code = `HBC_AC_LVL0;
        2'h1: ac_code = `HBC_AC_LVL1;
        2'h2: ac_code = `HBC_AC_LVL2;
        default: ac_code = `HBC_AC_LVL3;
      endcase
    end
  endfunction

  function [2:0] dc_code;
    input [1:0] lvl;
    begin
      case (lvl) // RULE1 RULE16
        `HBC_STRAP_LOW: dc_code = `HBC_DC_40MV;
        `HBC_STRAP_HIGH: dc_code = `HBC_DC_80MV;
        default: dc_code = `HBC_DC_60MV;
      endcase
    end
  endfunction

  // Pins cross in via flops before use: two for SCL, SDA and speed, three for disable and the straps
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dis_s1_ff <= 2'h0;
      dis_s2_ff <= 2'h0;
      scl_s_ff <= 2'h3;
      sda_s_ff <= 2'h3;
      spd_s1_ff <= 2'h0;
      spd_s2_ff <= 2'h0;
      ac_s1_ff <= 4'h0;
      ac_s2_ff <= 4'h0;
      dc_s1_ff <= 4'h0;
      dc_s2_ff <= 4'h0;
    end else begin
      dis_s1_ff <= {dis_s1_ff[0], chip_disable_n_i};
      dis_s2_ff <= dis_s1_ff;
      scl_s_ff <= {scl_s_ff[0], scl_i};
      sda_s_ff <= {sda_s_ff[0], sda_i};
      spd_s1_ff <= link_speed_i;
      spd_s2_ff <= spd_s1_ff;
      ac_s1_ff <= {ac_s1_ff[1:0], ac_boost_strap_pin_i};
      ac_s2_ff <= ac_s1_ff;
      dc_s1_ff <= {dc_s1_ff[1:0], dc_gain_strap_pin_i};
      dc_s2_ff <= dc_s1_ff;
    end
  end

  // Short glitches on the disable pin are filtered out
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      low_cnt_ff <= 32'h0;
      active_ff <= 1'b0;
    end else if (disable_pin) begin
      low_cnt_ff <= 32'h0;
      active_ff <= 1'b1;
    end else if (low_cnt_ff < DISABLE_MIN_CYC - 1) begin
      low_cnt_ff <= low_cnt_ff + 32'h1;
    end else begin
      active_ff <= 1'b0; // RULE7
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= ST_OFF;
      wait_ff <= 5'h0;
      i2c_mode_o <= 1'b0;
      ac_gain_level_ff <= `HBC_AC_LVL0;
      dc_gain_level_ff <= `HBC_DC_60MV;
      cfg_hold_ff <= `HBC_CFG_HOLD_RST;
    end else begin
      case (state_ff)
        ST_OFF: begin
          i2c_mode_o <= 1'b0;
          cfg_hold_ff <= `HBC_CFG_HOLD_RST; // RULE13 RULE19
          wait_ff <= 5'h0;
          if (active_ff) begin
            state_ff <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          wait_ff <= wait_ff + 5'h1;
          if (wait_ff == `HBC_SAMPLE_DELAY_CYC) begin
            // Straps taken once per release only
            ac_gain_level_ff <= ac_code(ac_s2_ff[3:2]); // RULE12 RULE17
            dc_gain_level_ff <= dc_code(dc_s2_ff[3:2]); // RULE16 RULE19
            i2c_mode_o <= scl_sync & sda_sync; // RULE8
            cfg_hold_ff <= scl_sync & sda_sync; // RULE14
            state_ff <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (wr_stb) begin // RULE18
            if (wr_ofs == `HBC_OFS_AC_GAIN) begin
              ac_gain_level_ff <= wr_data[`HBC_AC_MSB:`HBC_AC_LSB];
            end
            if (wr_ofs == `HBC_OFS_DC_GAIN) begin
              dc_gain_level_ff <= wr_data[`HBC_DC_MSB:`HBC_DC_LSB];
            end
            if (wr_ofs == `HBC_OFS_CFG_HOLD) begin
              cfg_hold_ff <= wr_data[0]; // RULE13 RULE14
            end
          end
        end
        default: begin
          state_ff <= ST_OFF;
        end
      endcase
      if (!active_ff) begin
        state_ff <= ST_OFF; // RULE6 RULE19
      end
    end
  end

  always @* begin
    case (rd_ofs)
      `HBC_OFS_AC_GAIN: rd_data = {1'b0, ac_gain_level_ff, 4'h0};
      `HBC_OFS_CFG_HOLD: rd_data = {7'h00, cfg_hold_ff};
      `HBC_OFS_DC_GAIN: rd_data = {5'h00, dc_gain_level_ff};
      default: rd_data = 8'h00;
    endcase
  end

  // Boost outputs reload only while running with hold clear
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      comp_enable_o <= 1'b0;
      ac_gain_level_o <= `HBC_AC_LVL0;
      dc_gain_level_o <= `HBC_DC_60MV;
      connection_detect_out_o <= 1'b0;
    end else if (state_ff != ST_RUN || cfg_hold_ff) begin
      comp_enable_o <= 1'b0; // RULE6 RULE10
      connection_detect_out_o <= 1'b0;
    end else begin
      ac_gain_level_o <= ac_gain_level_ff;
      dc_gain_level_o <= dc_gain_level_ff;
      comp_enable_o <= (spd_s2_ff == `HBC_SPEED_HS); // RULE3 RULE4 RULE5
      connection_detect_out_o <= (spd_s2_ff != `HBC_SPEED_NONE);
    end
  end

  hbc_i2c_target u_i2c (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .enable_i(i2c_mode_o),
    .scl_i(scl_sync),
    .sda_i(sda_sync),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .wr_stb_o(wr_stb),
    .wr_ofs_o(wr_ofs),
    .wr_data_o(wr_data),
    .rd_ofs_o(rd_ofs),
    .rd_data_i(rd_data)
  );
endmodule

// ===== hdl/hbc_i2c_target.v
// I2C target: byte-wide offset/data register access
`include "hbc_map.vh"
module hbc_i2c_target (
  input wire clock_i,
  input wire resetn_i,
  input wire enable_i,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  output reg wr_stb_o,
  output reg [7:0] wr_ofs_o,
  output reg [7:0] wr_data_o,
  output wire [7:0] rd_ofs_o,
  input wire [7:0] rd_data_i
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ACK = 3'h2;
  localparam ST_WBYTE = 3'h3;
  localparam ST_RBYTE = 3'h4;
  localparam ST_RACK = 3'h5;
  reg scl_d_ff;
  reg sda_d_ff;
  reg [2:0] state_ff;
  reg [2:0] after_ack_ff;
  reg [3:0] bit_cnt_ff;
  reg [7:0] shift_ff;
  reg [7:0] ofs_ff;
  reg byte_idx_ff;
  reg rw_ff;
  reg drive_low_ff;
  wire scl_rise = scl_i & ~scl_d_ff;
  wire scl_fall = ~scl_i & scl_d_ff;
  wire start_cond = scl_i & scl_d_ff & sda_d_ff & ~sda_i;
  wire stop_cond = scl_i & scl_d_ff & ~sda_d_ff & sda_i;
  assign sda_o = 1'b0;
  // Gated so a shutdown mid-byte never leaves the line held low
  assign sda_oe_o = drive_low_ff & enable_i;
  assign rd_ofs_o = ofs_ff;
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      state_ff <= ST_IDLE;
      after_ack_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ofs_ff <= 8'h00;
      byte_idx_ff <= 1'b0;
      rw_ff <= 1'b0;
      drive_low_ff <= 1'b0;
      wr_stb_o <= 1'b0;
      wr_ofs_o <= 8'h00;
      wr_data_o <= 8'h00;
    end else begin
      scl_d_ff <= scl_i;
      sda_d_ff <= sda_i;
      wr_stb_o <= 1'b0;
      if (!enable_i || stop_cond) begin
        state_ff <= ST_IDLE;
        drive_low_ff <= 1'b0;
      end else if (start_cond) begin
        state_ff <= ST_ADDR;
        bit_cnt_ff <= 4'h0;
        byte_idx_ff <= 1'b0;
        drive_low_ff <= 1'b0;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            drive_low_ff <= 1'b0;
          end
          ST_ADDR, ST_WBYTE: begin
            if (scl_rise) begin
              shift_ff <= {shift_ff[6:0], sda_i};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
            if (scl_fall && bit_cnt_ff == 4'h8) begin
              bit_cnt_ff <= 4'h0;
              if (state_ff == ST_ADDR) begin
                if (shift_ff[7:1] == `HBC_I2C_ADDR) begin // RULE9
                  rw_ff <= shift_ff[0];
                  drive_low_ff <= 1'b1;
                  state_ff <= ST_ACK;
                  after_ack_ff <= shift_ff[0] ? ST_RBYTE : ST_WBYTE;
                end else begin
                  state_ff <= ST_IDLE;
                end
              end else begin
                drive_low_ff <= 1'b1;
                state_ff <= ST_ACK;
                after_ack_ff <= ST_WBYTE;
                if (!byte_idx_ff) begin
                  ofs_ff <= shift_ff; // RULE18
                  byte_idx_ff <= 1'b1;
                end else begin
                  wr_stb_o <= 1'b1; // RULE18
                  wr_ofs_o <= ofs_ff;
                  wr_data_o <= shift_ff;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              state_ff <= after_ack_ff;
              if (after_ack_ff == ST_RBYTE) begin
                shift_ff <= {rd_data_i[6:0], 1'b0};
                drive_low_ff <= ~rd_data_i[7]; // RULE18
                bit_cnt_ff <= 4'h1;
              end else begin
                drive_low_ff <= 1'b0;
              end
            end
          end
          ST_RBYTE: begin
            if (scl_fall) begin
              if (bit_cnt_ff == 4'h8) begin
                drive_low_ff <= 1'b0;
                state_ff <= ST_RACK;
              end else begin
                drive_low_ff <= ~shift_ff[7];
                shift_ff <= {shift_ff[6:0], 1'b0};
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
              end
            end
          end
          ST_RACK: begin
            // Host NACK ends the read; ACK re-reads same offset
            if (scl_rise) begin
              state_ff <= sda_i ? ST_IDLE : ST_ACK;
              after_ack_ff <= ST_RBYTE;
            end
          end
          default: begin
            state_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// ===== hdl/hbc_map.vh
// Register map, field positions and timing constants of the boost control
`ifndef HBC_MAP_VH
`define HBC_MAP_VH
`define HBC_I2C_ADDR 7'h2C
`define HBC_OFS_AC_GAIN 8'h01
`define HBC_OFS_CFG_HOLD 8'h03
`define HBC_OFS_DC_GAIN 8'h0E
`define HBC_AC_LSB 4
`define HBC_AC_MSB 6
`define HBC_DC_LSB 0
`define HBC_DC_MSB 2
`define HBC_AC_LVL0 3'h0
`define HBC_AC_LVL1 3'h1
`define HBC_AC_LVL2 3'h3
`define HBC_AC_LVL3 3'h7
`define HBC_DC_40MV 3'h3
`define HBC_DC_60MV 3'h5
`define HBC_DC_80MV 3'h7
`define HBC_STRAP_LOW 2'h0
`define HBC_STRAP_MID 2'h1
`define HBC_STRAP_HIGH 2'h2
`define HBC_SPEED_NONE 2'h0
`define HBC_SPEED_LS 2'h1
`define HBC_SPEED_FS 2'h2
`define HBC_SPEED_HS 2'h3
`define HBC_CFG_HOLD_RST 1'h1
`define HBC_DISABLE_MIN_NS 20000
`define HBC_CLK_PERIOD_NS 4
`define HBC_DISABLE_MIN_CYC \
  ((`HBC_DISABLE_MIN_NS + `HBC_CLK_PERIOD_NS - 1) / `HBC_CLK_PERIOD_NS)
`define HBC_SAMPLE_DELAY_CYC 16
`endif

// ===== sim/hbc_boost_ctrl_props.sv
// Port checks of the boost control block
module hbc_boost_ctrl_props #(
  parameter int DISABLE_MIN_CYC = 5000
) (
  input logic clock_i,
  input logic resetn_i,
  input logic chip_disable_n_i,
  input logic [1:0] link_speed_i,
  input logic sda_o,
  input logic sda_oe_o,
  input logic comp_enable_o,
  input logic [2:0] ac_gain_level_o,
  input logic [2:0] dc_gain_level_o,
  input logic connection_detect_out_o,
  input logic i2c_mode_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] lo_cnt_ff;
  logic [15:0] hi_cnt_ff;
  // Saturating, so a long run never wraps into a false short pulse
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lo_cnt_ff <= 16'h0;
      hi_cnt_ff <= 16'h0;
    end else begin
      lo_cnt_ff <= chip_disable_n_i ? 16'h0 : lo_cnt_ff + 16'(!lo_cnt_ff[15]);
      hi_cnt_ff <= chip_disable_n_i ? hi_cnt_ff + 16'(!hi_cnt_ff[15]) : 16'h0;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  a_comp_needs_hs: assert property (comp_enable_o |->
    $past(link_speed_i, 2) == 2'h3 || $past(link_speed_i, 3) == 2'h3 ||
    $past(link_speed_i, 4) == 2'h3) else $error("comp without hs");
  a_detect_needs_link: assert property (connection_detect_out_o |->
    $past(link_speed_i, 2) != 2'h0 || $past(link_speed_i, 3) != 2'h0 ||
    $past(link_speed_i, 4) != 2'h0) else $error("detect without link");
  a_comp_with_detect: assert property (
    comp_enable_o |-> connection_detect_out_o) else $error("comp alone");
  a_shutdown_quiet: assert property (lo_cnt_ff > DISABLE_MIN_CYC + 8 |->
    !comp_enable_o && !connection_detect_out_o) else $error("not shut");
  a_sda_open_drain: assert property (
    sda_o == 1'b0) else $error("sda driven high");
  a_ack_needs_mode: assert property (
    sda_oe_o |-> i2c_mode_o) else $error("bus answered off mode");
  a_mode_settled: assert property (hi_cnt_ff > 64 |->
    $stable(i2c_mode_o)) else $error("mode changed late");
  a_ac_code_legal: assert property (
    ac_gain_level_o inside {3'h0, 3'h1, 3'h3, 3'h7}) else $error("ac code");
  a_dc_code_legal: assert property (
    dc_gain_level_o inside {3'h3, 3'h5, 3'h7}) else $error("dc code");
  cover property (comp_enable_o);
  cover property (connection_detect_out_o && !comp_enable_o);
  cover property (sda_oe_o);
  cover property (lo_cnt_ff > DISABLE_MIN_CYC + 8);
endmodule
bind hbc_boost_ctrl hbc_boost_ctrl_props #(
  .DISABLE_MIN_CYC(DISABLE_MIN_CYC)
) i_props (
  .clock_i(clock_i), .resetn_i(resetn_i),
  .chip_disable_n_i(chip_disable_n_i), .link_speed_i(link_speed_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .comp_enable_o(comp_enable_o),
  .ac_gain_level_o(ac_gain_level_o), .dc_gain_level_o(dc_gain_level_o),
  .connection_detect_out_o(connection_detect_out_o),
  .i2c_mode_o(i2c_mode_o)
);

// ===== sim/hbc_i2c_host.sv
// Behavioural I2C host for the configuration bus
module hbc_i2c_host (
  input wire sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int Q = 80;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Holds data low across release to pick pin mode
  task automatic pull_sda(input logic b);
    sda_low_o = b;
  endtask
  task automatic start();
    #(Q / 2);
    sda_low_o = 1'b0;
    #(Q / 2);
    scl_o = 1'b1;
    #(Q / 2);
    sda_low_o = 1'b1;
    #(Q / 2);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    #(Q / 2);
    sda_low_o = 1'b1;
    #(Q / 2);
    scl_o = 1'b1;
    #(Q / 2);
    sda_low_o = 1'b0;
    #(Q / 2);
  endtask
  // Data moves only mid-low, away from both clock edges
  task automatic bit_io(input logic b, output logic r);
    #(Q / 2);
    sda_low_o = !b;
    #(Q / 2);
    scl_o = 1'b1;
    // Low and high phase of Q each, a 160 ns bit
    #(Q / 2);
    r = sda_i;
    #(Q / 2);
    scl_o = 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic m,
                       output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(m, a);
  endtask
endmodule

// ===== sim/testbench.sv
// Self-checking bench of the boost control block
`include "hbc_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DMIN = 20;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cdn_i = 1'b1;
  logic [1:0] ac_s = 2'h3;
  logic [1:0] dc_s = 2'h0;
  logic [1:0] spd = 2'h0;
  logic [31:0] seed = 32'hB8B7FA9D;
  logic [7:0] v;
  logic [7:0] ac_r;
  logic [7:0] dc_r;
  logic [2:0] a_x;
  logic [2:0] d_x;
  int n_errors = 0;
  int checks_done = 0;
  wire scl;
  wire hl;
  wire sda_o;
  wire sda_oe;
  wire comp;
  wire cd;
  wire mode;
  wire [2:0] ac_o;
  wire [2:0] dc_o;
  wire sda = !hl && !(sda_oe && !sda_o);
  always #2 clock_i = ~clock_i;
  hbc_i2c_host i_hbc_i2c_host (.sda_i(sda), .scl_o(scl), .sda_low_o(hl));
  hbc_boost_ctrl #(.DISABLE_MIN_CYC(DMIN)) i_hbc_boost_ctrl (
    .clock_i(clock_i), .resetn_i(resetn_i), .chip_disable_n_i(cdn_i),
    .ac_boost_strap_pin_i(ac_s), .dc_gain_strap_pin_i(dc_s),
    .link_speed_i(spd), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .comp_enable_o(comp), .ac_gain_level_o(ac_o),
    .dc_gain_level_o(dc_o), .connection_detect_out_o(cd),
    .i2c_mode_o(mode));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [2:0] ac_code(input logic [1:0] l);
    return {l == 2'h3, l >= 2'h2, l != 2'h0};
  endfunction
  function automatic logic [2:0] dc_code(input logic [1:0] l);
    return {l != 2'h0, !l[0], 1'b1};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic cmp(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    logic [7:0] r;
    logic [2:0] a;
    i_hbc_i2c_host.start();
    i_hbc_i2c_host.xbyte({`HBC_I2C_ADDR, 1'b0}, 1'b1, r, a[2]);
    i_hbc_i2c_host.xbyte(o, 1'b1, r, a[1]);
    i_hbc_i2c_host.xbyte(d, 1'b1, r, a[0]);
    i_hbc_i2c_host.stop();
    cmp("write ack", 8'h0, 8'(a));
  endtask
  task automatic rd(input logic [7:0] o, output logic [7:0] d);
    logic [7:0] r;
    logic [2:0] a;
    i_hbc_i2c_host.start();
    i_hbc_i2c_host.xbyte({`HBC_I2C_ADDR, 1'b0}, 1'b1, r, a[2]);
    i_hbc_i2c_host.xbyte(o, 1'b1, r, a[1]);
    i_hbc_i2c_host.start();
    i_hbc_i2c_host.xbyte({`HBC_I2C_ADDR, 1'b1}, 1'b1, r, a[0]);
    i_hbc_i2c_host.xbyte(8'hFF, 1'b1, d, r[0]);
    i_hbc_i2c_host.stop();
    cmp("read ack", 8'h0, 8'(a));
  endtask
  task automatic link(input logic on);
    for (int s = 0; s < 4; s++) begin
      spd = 2'(s);
      tick(8);
      cmp("comp", 8'(on && s == 3), 8'(comp));
      cmp("detect", 8'(on && s != 0), 8'(cd));
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    // Roughly twice the expected run, well under the cycle budget
    #300us;
    n_errors++;
    print_verdict();
  end
  initial begin
    tick(20);
    resetn_i = 1'b1;
    for (int k = 0; k < 4; k++) begin
      if (k > 0) begin
        ac_s = 2'(rnd());
        dc_s = 2'(rnd());
        cdn_i = 1'b0;
        spd = 2'h3;
        i_hbc_i2c_host.pull_sda(k == 1);
        tick(DMIN + 12);
        cmp("shutdown", 8'h0, {6'h0, comp, cd});
        cdn_i = 1'b1;
      end
      tick(80);
      i_hbc_i2c_host.pull_sda(1'b0);
      a_x = ac_code(ac_s);
      d_x = dc_code(dc_s);
      cmp("i2c mode", 8'(k != 1), 8'(mode));
      if (k != 1) begin
        rd(`HBC_OFS_AC_GAIN, ac_r);
        cmp("ac reg", 8'(a_x), 8'(ac_r[6:4]));
        rd(`HBC_OFS_DC_GAIN, dc_r);
        cmp("dc reg", 8'(d_x), 8'(dc_r[2:0]));
        rd(`HBC_OFS_CFG_HOLD, v);
        cmp("hold reg", 8'h1, 8'(v[0]));
        link(1'b0);
        wr(`HBC_OFS_CFG_HOLD, v & 8'hFE);
      end
      link(1'b1);
      cmp("ac out", 8'(a_x), 8'(ac_o));
      cmp("dc out", 8'(d_x), 8'(dc_o));
      $display("strap pass %0d done", k);
    end
    for (int l = 0; l < 4; l++) begin
      a_x = ac_code(2'(l));
      d_x = dc_code(2'(rnd()));
      wr(`HBC_OFS_AC_GAIN, {ac_r[7], a_x, ac_r[3:0]});
      wr(`HBC_OFS_DC_GAIN, {dc_r[7:3], d_x});
      wr(`HBC_OFS_CFG_HOLD, v | 8'h01);
      wr(`HBC_OFS_CFG_HOLD, v & 8'hFE);
      tick(8);
      cmp("ac out", 8'(a_x), 8'(ac_o));
      cmp("dc out", 8'(d_x), 8'(dc_o));
    end
    $display("level writes done");
    ac_s = ~ac_s;
    dc_s = ~dc_s;
    cdn_i = 1'b0;
    tick(DMIN / 2);
    cdn_i = 1'b1;
    tick(40);
    cmp("ac kept", 8'(a_x), 8'(ac_o));
    cmp("short low", 8'h1, 8'(comp));
    rd(`HBC_OFS_CFG_HOLD, v);
    cmp("hold kept", 8'h0, 8'(v[0]));
    i_hbc_i2c_host.start();
    i_hbc_i2c_host.xbyte({7'h2D, 1'b0}, 1'b1, ac_r, v[0]);
    i_hbc_i2c_host.stop();
    cmp("foreign nack", 8'h1, 8'(v[0]));
    rd(8'h05, v);
    cmp("unmapped", 8'h0, v);
    $display("corner cases done");
    print_verdict();
  end
endmodule
